// ### core/sse_pkg.sv
package sse_pkg;
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          PROG_TIME_NS   = 5_000_000;
  localparam int          CYC_W          = 20;
  localparam logic [CYC_W-1:0] PROG_CYC_DEF = CYC_W'(PROG_TIME_NS / CLK_PERIOD_NS);
  localparam int          ADDR_W         = 15;
  localparam int          PAGE_BYTES     = 64;
  localparam int          PAGE_AW        = $clog2(PAGE_BYTES);
  localparam int          CNT_W          = PAGE_AW + 1;
  localparam logic [CNT_W-1:0] CNT_FULL  = CNT_W'(PAGE_BYTES);
  localparam logic [7:0]  OP_LATCH_SET   = 8'h06;
  localparam logic [7:0]  OP_LATCH_CLEAR = 8'h04;
  localparam logic [7:0]  OP_READ        = 8'h03;
  localparam logic [7:0]  OP_WRITE       = 8'h02;
  localparam logic [7:0]  OP_STAT_READ   = 8'h05;
  localparam logic [7:0]  OP_STAT_WRITE  = 8'h01;
  localparam int          ST_GATE        = 7;
  localparam int          ST_BP_HI       = 3;
  localparam int          ST_BP_LO       = 2;
  localparam logic [2:0]  ST_ZERO        = 3'h0;
  localparam logic [2:0]  BIT_LAST       = 3'h7;
  localparam logic [1:0]  BP_NONE        = 2'h0;
  localparam logic [1:0]  BP_QUARTER     = 2'h1;
  localparam logic [1:0]  BP_HALF        = 2'h2;
  localparam logic [1:0]  BP_TOP_QUARTER = 2'h3;
  localparam logic [7:0]  ARRAY_INIT     = 8'hFF;
  localparam logic [2:0]  NV_INIT        = 3'h0;

  typedef enum logic [1:0] {PH_OP, PH_ADDR, PH_DATA, PH_IDLE} sse_phase_t;
  typedef enum logic [1:0] {S_IDLE, S_COPY, S_WAIT} sse_prog_t;

  typedef struct packed {
    logic protect_pin_gate;
    logic protect_block_sel_hi;
    logic protect_block_sel_lo;
  } sse_nv_t;

  typedef struct packed {
    logic set_tg;
    logic clr_tg;
    logic arm;
  } sse_l2s_t;

  typedef struct packed {
    sse_nv_t nv;
    logic    wel;
    logic    busy;
  } sse_s2l_t;

  typedef struct packed {
    logic     cs_n;
    logic     wp_n;
    logic     low;
    sse_l2s_t l2s;
  } sse_pin_t;
endpackage

// ### core/sse_mem.sv
`timescale 1ns/10ps
module sse_mem #(
  parameter int            AW   = 1,
  parameter int            DW   = 8,
  parameter logic [DW-1:0] INIT = '0
) (
  input  wire logic          wclk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic          rclk,
  input  wire logic          re,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [2**AW];

  // Contents model cells that keep their value without power
  initial begin
    for (int i = 0; i < 2**AW; i++) begin
      mem[i] = INIT;
    end
  end

  always @(posedge wclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge rclk) begin
    if (re) begin
      rdata <= mem[raddr];
    end
  end
endmodule

// ### core/sse_eeprom.sv
`timescale 1ns/10ps
// What this block does
// R1 - Link works in clock modes zero/zero and one/one only.
// R2 - Input sampled on rising link clock edge, most significant bit first.
// R3 - Output bit changes after falling link clock edge, most significant bit first.
// R4 - Page write programs several consecutive bytes in one internal cycle.
// R5 - Write-enable latch comes up cleared after power returns.
// R6 - Disable command clears the latch; array and status writes then refused.
// R7 - Block-protect bits change only by status write and survive power loss.
// R8 - Writes into protected region ignored; reads still work.
// R9 - Busy flag shows internal write cycle; status write cannot change it.
// R10 - Status read shifts out the current eight-bit status word.
// R11 - Delivered array holds all ones; gate and protect bits zero.
// R12 - Pause input low suspends transfer without aborting it.
// R13 - Write-protect pin asserted refuses the status write while gate bit 7 is set.
// R14 - Read address advances after each byte; clocking continues through memory.
// R15 - Each rewrite erases and programs by itself and ends by itself.
// R16 - Low supply inhibits internal write cycles.
// R17 - Opcode 06 sets the latch, 04 clears it, taken after opcode.
// R18 - Only gate bit 7 and protect bits 3 and 2 are writable.
// R19 - Array write needs latch set beforehand and clears it when executed.
// R20 - While paused: link clock and input ignored, output floats, resume same bit.
// R21 - Chip select low begins a command; raising it returns to idle.
module sse_eeprom
  import sse_pkg::*;
#(
  parameter logic [sse_pkg::CYC_W-1:0] PROG_CYC = sse_pkg::PROG_CYC_DEF
) (
  input  wire logic CLK,
  input  wire logic RST_B,
  input  wire logic SER_CLK,
  input  wire logic CHIP_SELECT_N,
  input  wire logic SER_IN,
  output logic      SER_OUT,
  output logic      SER_OUT_OE,
  input  wire logic PAUSE_TRANSFER_N,
  input  wire logic WRITE_PROTECT_N,
  input  wire logic SUPPLY_LOW
);
  import sse_pkg::*;

  typedef struct packed {
    sse_phase_t ph;
    logic [2:0] bcnt;
    logic       abyte;
    logic [6:0] sr;
  } sse_lkf_t;

  typedef struct packed {
    logic [7:0]         op;
    logic [7:0]         ahi;
    logic [ADDR_W-1:0]  addr;
    logic [PAGE_AW-1:0] pofs;
    logic [CNT_W-1:0]   cnt;
    sse_nv_t            stat_w;
    logic               arm;
    logic               set_tg;
    logic               clr_tg;
    sse_s2l_t           s1;
    sse_s2l_t           s2;
    logic [7:0]         out_byte;
  } sse_lkp_t;

  typedef struct packed {
    logic so;
    logic oe;
  } sse_lkq_t;

  typedef struct packed {
    sse_pin_t           sy1;
    sse_pin_t           sy2;
    logic               cs_prev;
    logic               wel;
    logic               used;
    sse_prog_t          st;
    logic               busy;
    logic [CNT_W-1:0]   idx;
    logic               wr_v;
    logic [PAGE_AW-1:0] wr_off;
    logic [ADDR_W-1:0]  base;
    logic [CNT_W-1:0]   n;
    logic [CYC_W-1:0]   cyc;
    logic               set_seen;
    logic               clr_seen;
    logic               nv_we;
    sse_nv_t            nv_d;
    logic               lk_rst_n;
  } sse_sys_t;

  localparam sse_lkf_t LKF_RST = '{ph: PH_OP, default: '0};
  localparam sse_sys_t SYS_RST = '{st: S_IDLE, default: '0};

  sse_lkf_t           f_q, f_d;
  sse_lkp_t           p_q, p_d;
  sse_lkq_t           o_q, o_d;
  sse_sys_t           s_q, s_d;
  sse_nv_t            nv_q;
  sse_s2l_t           s2l_src;
  sse_l2s_t           l2s_src;
  logic [7:0]         bit_in;
  logic [15:0]        a16;
  logic               byte_done;
  logic               arr_re;
  logic [ADDR_W-1:0]  arr_raddr;
  logic [7:0]         arr_rdata;
  logic               pb_we;
  logic [7:0]         pb_rdata;
  logic [PAGE_AW-1:0] pb_raddr;
  logic [7:0]         cur_byte;
  logic               out_op;
  logic               evt_set;
  logic               evt_clr;
  logic               cs_rise;
  logic               commit;
  logic               prot_hit;

  function automatic logic [7:0] stat_byte(input sse_s2l_t s);
    return {s.nv.protect_pin_gate, ST_ZERO, s.nv.protect_block_sel_hi,
            s.nv.protect_block_sel_lo, s.wel, s.busy};
  endfunction

  function automatic logic in_protected(input sse_nv_t nv, input logic [ADDR_W-1:0] a);
    unique case ({nv.protect_block_sel_hi, nv.protect_block_sel_lo})
      BP_NONE:        return 1'b0;
      BP_QUARTER:     return a[ADDR_W-1] & a[ADDR_W-2];
      BP_HALF:        return a[ADDR_W-1];
      BP_TOP_QUARTER: return 1'b1;
    endcase
  endfunction

  assign s2l_src = '{nv: nv_q, wel: s_q.wel, busy: s_q.busy};
  assign l2s_src = '{set_tg: p_q.set_tg, clr_tg: p_q.clr_tg, arm: p_q.arm};

  // Link side, rising edge: command decode and input shift
  always_comb begin
    f_d       = f_q;
    p_d       = p_q;
    arr_re    = 1'b0;
    arr_raddr = p_q.addr;
    pb_we     = 1'b0;
    bit_in    = {f_q.sr, SER_IN}; // R2
    a16       = {p_q.ahi, bit_in};
    byte_done = f_q.bcnt == BIT_LAST;
    p_d.s1    = s2l_src;
    p_d.s2    = p_q.s1;
    if (PAUSE_TRANSFER_N) begin // R12 R20
      p_d.arm  = 1'b0;
      f_d.bcnt = f_q.bcnt + 3'h1; // R1
      f_d.sr   = bit_in[6:0];
      if (byte_done) begin
        unique case (f_q.ph)
          PH_OP: begin
            p_d.op    = bit_in;
            f_d.ph    = PH_IDLE;
            f_d.abyte = 1'b0;
            if (bit_in == OP_READ || bit_in == OP_WRITE) begin
              f_d.ph = PH_ADDR;
            end
            if (bit_in == OP_STAT_READ) begin
              f_d.ph       = PH_DATA;
              p_d.out_byte = stat_byte(p_q.s2); // R10
            end
            if (bit_in == OP_STAT_WRITE) begin
              f_d.ph = PH_DATA;
            end
            if (bit_in == OP_LATCH_SET) begin
              p_d.set_tg = ~p_q.set_tg; // R17
            end
            if (bit_in == OP_LATCH_CLEAR) begin
              p_d.clr_tg = ~p_q.clr_tg; // R17 R6
            end
          end
          PH_ADDR: begin
            f_d.abyte = 1'b1;
            p_d.ahi   = bit_in;
            if (f_q.abyte) begin
              p_d.addr = a16[ADDR_W-1:0];
              p_d.pofs = a16[PAGE_AW-1:0];
              p_d.cnt  = '0;
              f_d.ph   = PH_DATA;
              if (p_q.op == OP_READ) begin
                if (p_q.s2.busy) begin
                  f_d.ph = PH_IDLE;
                end else begin
                  arr_re    = 1'b1;
                  arr_raddr = a16[ADDR_W-1:0];
                end
              end
            end
          end
          PH_DATA: begin
            if (p_q.op == OP_READ) begin
              arr_re    = 1'b1;
              arr_raddr = ADDR_W'(p_q.addr + 1'b1); // R14
              p_d.addr  = ADDR_W'(p_q.addr + 1'b1);
            end
            if (p_q.op == OP_WRITE) begin
              pb_we    = 1'b1; // R4
              p_d.pofs = PAGE_AW'(p_q.pofs + 1'b1);
              p_d.arm  = 1'b1;
              if (p_q.cnt != CNT_FULL) begin
                p_d.cnt = CNT_W'(p_q.cnt + 1'b1);
              end
            end
            if (p_q.op == OP_STAT_WRITE) begin
              p_d.stat_w = '{protect_pin_gate:     bit_in[ST_GATE],
                             protect_block_sel_hi: bit_in[ST_BP_HI],
                             protect_block_sel_lo: bit_in[ST_BP_LO]}; // R18
              p_d.arm    = 1'b1;
              f_d.ph     = PH_IDLE;
            end
            if (p_q.op == OP_STAT_READ) begin
              p_d.out_byte = stat_byte(p_q.s2); // R10
            end
          end
          PH_IDLE: begin
          end
        endcase
      end
    end
  end

  // Frame state ends with the frame itself
  always_ff @(posedge SER_CLK or posedge CHIP_SELECT_N) begin
    if (CHIP_SELECT_N) begin
      f_q <= LKF_RST; // R21
    end else begin
      f_q <= f_d;
    end
  end

  always_ff @(posedge SER_CLK or negedge s_q.lk_rst_n) begin
    if (!s_q.lk_rst_n) begin
      p_q <= '0;
    end else begin
      p_q <= p_d;
    end
  end

  // Link side, falling edge: output shift
  assign out_op   = p_q.op == OP_READ || p_q.op == OP_STAT_READ;
  assign cur_byte = (p_q.op == OP_READ) ? arr_rdata : p_q.out_byte;

  always_comb begin
    o_d = o_q;
    if (PAUSE_TRANSFER_N) begin
      o_d.oe = f_q.ph == PH_DATA && out_op;
      o_d.so = cur_byte[~f_q.bcnt]; // R3
    end
  end

  always_ff @(negedge SER_CLK or posedge CHIP_SELECT_N) begin
    if (CHIP_SELECT_N) begin
      o_q <= '0;
    end else begin
      o_q <= o_d;
    end
  end

  assign SER_OUT    = o_q.so;
  assign SER_OUT_OE = o_q.oe & PAUSE_TRANSFER_N & ~CHIP_SELECT_N; // R20

  // System side: latch, commit and internal write cycle
  assign evt_set  = s_q.sy2.l2s.set_tg ^ s_q.set_seen;
  assign evt_clr  = s_q.sy2.l2s.clr_tg ^ s_q.clr_seen;
  assign cs_rise  = s_q.sy2.cs_n & ~s_q.cs_prev;
  assign commit   = cs_rise & s_q.sy2.l2s.arm & ~s_q.used & ~s_q.busy
                    & s_q.wel & ~s_q.sy2.low; // R19 R16
  assign prot_hit = in_protected(nv_q, p_q.addr);
  assign pb_raddr = PAGE_AW'(s_q.base[PAGE_AW-1:0] + s_q.idx[PAGE_AW-1:0]);

  always_comb begin
    s_d          = s_q;
    s_d.sy1      = '{cs_n: CHIP_SELECT_N, wp_n: WRITE_PROTECT_N, low: SUPPLY_LOW,
                     l2s: l2s_src};
    s_d.sy2      = s_q.sy1;
    s_d.cs_prev  = s_q.sy2.cs_n;
    s_d.lk_rst_n = 1'b1;
    s_d.nv_we    = 1'b0;
    s_d.wr_v     = 1'b0;
    s_d.set_seen = s_q.sy2.l2s.set_tg;
    s_d.clr_seen = s_q.sy2.l2s.clr_tg;
    if (!s_q.busy) begin
      if (evt_clr) begin
        s_d.wel = 1'b0; // R6
      end
      if (evt_set) begin
        s_d.wel = 1'b1; // R17
      end
    end
    if (!s_q.sy2.l2s.arm) begin
      s_d.used = 1'b0;
    end
    if (cs_rise && s_q.sy2.l2s.arm) begin
      s_d.used = 1'b1;
    end
    if (commit) begin
      if (p_q.op == OP_WRITE && !prot_hit) begin // R8
        s_d.st   = S_COPY;
        s_d.base = p_q.addr;
        s_d.n    = p_q.cnt;
        s_d.idx  = '0;
        s_d.wel  = 1'b0; // R19
      end
      if (p_q.op == OP_STAT_WRITE &&
          (s_q.sy2.wp_n || !nv_q.protect_pin_gate)) begin // R13
        s_d.nv_we = 1'b1; // R7
        s_d.nv_d  = p_q.stat_w;
        s_d.st    = S_WAIT;
        s_d.cyc   = '0;
        s_d.wel   = 1'b0;
      end
    end
    unique case (s_q.st)
      S_IDLE: begin
      end
      S_COPY: begin
        s_d.wr_v   = 1'b1; // R15
        s_d.wr_off = pb_raddr;
        s_d.idx    = CNT_W'(s_q.idx + 1'b1);
        if (s_q.idx == CNT_W'(s_q.n - 1'b1)) begin
          s_d.st  = S_WAIT;
          s_d.cyc = '0;
        end
      end
      S_WAIT: begin
        s_d.cyc = CYC_W'(s_q.cyc + 1'b1);
        if (s_q.cyc == CYC_W'(PROG_CYC - 1'b1)) begin
          s_d.st = S_IDLE; // R15
        end
      end
    endcase
    s_d.busy = s_d.st != S_IDLE; // R9
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      s_q <= SYS_RST; // R5
    end else begin
      s_q <= s_d;
    end
  end

  sse_mem #(.AW(ADDR_W), .DW(8), .INIT(ARRAY_INIT)) u_array ( // R11
    .wclk  (CLK),
    .we    (s_q.wr_v),
    .waddr ({s_q.base[ADDR_W-1:PAGE_AW], s_q.wr_off}),
    .wdata (pb_rdata),
    .rclk  (SER_CLK),
    .re    (arr_re),
    .raddr (arr_raddr),
    .rdata (arr_rdata)
  );

  sse_mem #(.AW(PAGE_AW), .DW(8), .INIT(ARRAY_INIT)) u_page (
    .wclk  (SER_CLK),
    .we    (pb_we),
    .waddr (p_q.pofs),
    .wdata (bit_in),
    .rclk  (CLK),
    .re    (1'b1),
    .raddr (pb_raddr),
    .rdata (pb_rdata)
  );

  sse_mem #(.AW(1), .DW(3), .INIT(NV_INIT)) u_nv ( // R7 R11
    .wclk  (CLK),
    .we    (s_q.nv_we),
    .waddr (1'b0),
    .wdata (s_q.nv_d),
    .rclk  (CLK),
    .re    (1'b1),
    .raddr (1'b0),
    .rdata (nv_q)
  );

  sequence seq_start;
    s_q.st == S_IDLE ##1 s_q.st != S_IDLE;
  endsequence

  sequence seq_cmd_status_write_refused;
    commit && p_q.op == OP_STAT_WRITE && nv_q.protect_pin_gate && !s_q.sy2.wp_n;
  endsequence

  a_wel_set_cmd: assert property (@(posedge CLK) disable iff (!RST_B) // R17
    evt_set && !s_q.busy && !commit |=> s_q.wel)
    else $error("latch not set by enable command");
  a_wel_clear_cmd: assert property (@(posedge CLK) disable iff (!RST_B) // R6
    evt_clr && !evt_set && !s_q.busy |=> !s_q.wel)
    else $error("latch not cleared by disable command");
  a_wel_spent: assert property (@(posedge CLK) disable iff (!RST_B) // R19
    seq_start |-> !s_q.wel && $past(s_q.wel))
    else $error("write cycle started without latch or latch kept");
  a_prog_hold: assert property (@(posedge CLK) disable iff (!RST_B) // R15
    s_q.st == S_WAIT && s_q.cyc != CYC_W'(PROG_CYC - 1'b1) |=> s_q.st == S_WAIT)
    else $error("write cycle ended early");
  a_busy_mirror: assert property (@(posedge CLK) disable iff (!RST_B) // R9
    commit && p_q.op == OP_WRITE && !prot_hit |=> s_q.busy && s_q.st == S_COPY)
    else $error("busy flag not raised by accepted write");
  a_protect_skip: assert property (@(posedge CLK) disable iff (!RST_B) // R8
    commit && p_q.op == OP_WRITE && prot_hit |=> s_q.st == S_IDLE)
    else $error("protected write started");
  a_gate_blocks: assert property (@(posedge CLK) disable iff (!RST_B) // R13
    seq_cmd_status_write_refused |=> !s_q.nv_we [*2])
    else $error("status write not refused under write protect");
  a_low_inhibit: assert property (@(posedge CLK) disable iff (!RST_B) // R16
    s_q.st == S_IDLE && s_q.sy2.low |=> s_q.st == S_IDLE)
    else $error("write cycle started at low supply");
  a_read_step: assert property (@(posedge SER_CLK) disable iff (CHIP_SELECT_N) // R14
    f_q.ph == PH_DATA && p_q.op == OP_READ && byte_done && PAUSE_TRANSFER_N
    |=> p_q.addr == ADDR_W'($past(p_q.addr) + 1'b1))
    else $error("read address did not advance");
  a_hold_freeze: assert property (@(posedge SER_CLK) disable iff (CHIP_SELECT_N) // R12
    !PAUSE_TRANSFER_N |=> $stable(f_q) && $stable(p_q.op))
    else $error("transfer moved while paused");
endmodule

// ### sim/sse_host_model.sv
`timescale 1ns/10ps
module sse_host_model (
  output logic      ser_clk,
  output logic      chip_select_n,
  output logic      ser_in,
  output logic      pause_transfer_n,
  input  wire logic ser_out,
  input  wire logic ser_out_oe
);
  localparam realtime HALF = 62.5;
  int   hold_bit;
  int   bit_cnt;
  logic idle_hi;
  logic hold_oe;
  logic last_so;

  initial begin
    ser_clk          = 1'b0;
    chip_select_n    = 1'b0;
    ser_in           = 1'b0;
    pause_transfer_n = 1'b1;
    hold_bit         = -1;
    bit_cnt          = 0;
    idle_hi          = 1'b0;
    hold_oe          = 1'b0;
    last_so          = 1'b0;
    // A clean deselect edge clears the frame logic before the first frame
    #1;
    chip_select_n    = 1'b1;
  end

  // Clock idles at the mode's level while deselected
  task automatic begin_frame(input logic mode_hi);
    idle_hi = mode_hi;
    ser_clk = mode_hi;
    #(HALF);
    chip_select_n = 1'b0;
    bit_cnt = 0;
    #(HALF);
  endtask

  // Pause only while the clock is low, wiggle clock and data meanwhile
  task automatic pause();
    #(HALF / 2);
    pause_transfer_n = 1'b0;
    #(HALF);
    hold_oe = ser_out_oe;
    ser_clk = 1'b1;
    ser_in = ~ser_in;
    #(HALF);
    ser_clk = 1'b0;
    hold_oe = hold_oe | ser_out_oe;
    #(HALF);
    pause_transfer_n = 1'b1;
    hold_bit = -1;
  endtask

  // Undriven output reads as a changing pattern, never as the last bit
  task automatic shift(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    int i;
    rx = 8'h00;
    for (i = 7; i > 7 - nb; i--) begin
      ser_clk = 1'b0;
      if (bit_cnt == hold_bit) pause();
      ser_in = tx[i];
      #(HALF);
      last_so = ser_out_oe ? ser_out : ~last_so;
      rx[i] = last_so;
      ser_clk = 1'b1;
      bit_cnt++;
      #(HALF);
    end
  endtask

  task automatic end_frame();
    if (!idle_hi) ser_clk = 1'b0;
    #(HALF);
    chip_select_n = 1'b1;
    ser_in = ~ser_in;
    #(250);
  endtask
endmodule

// ### sim/sse_eeprom_bench.sv
`timescale 1ns/10ps
module sse_eeprom_bench;
  import sse_pkg::*;
  logic        CLK;
  logic        RST_B;
  logic        SER_CLK;
  logic        CHIP_SELECT_N;
  logic        SER_IN;
  logic        SER_OUT;
  logic        SER_OUT_OE;
  logic        PAUSE_TRANSFER_N;
  logic        WRITE_PROTECT_N;
  logic        SUPPLY_LOW;
  logic [31:0] seed;
  int          miscompares;
  int          checked;
  logic [7:0]  ref_mem [int];
  logic [2:0]  nv;
  logic        wel;
  logic [7:0]  st;
  logic [7:0]  rx;
  logic [31:0] r;
  int          n;

  sse_eeprom #(.PROG_CYC(20'h190)) u_sse_eeprom (
    .CLK(CLK), .RST_B(RST_B), .SER_CLK(SER_CLK), .CHIP_SELECT_N(CHIP_SELECT_N),
    .SER_IN(SER_IN), .SER_OUT(SER_OUT), .SER_OUT_OE(SER_OUT_OE),
    .PAUSE_TRANSFER_N(PAUSE_TRANSFER_N), .WRITE_PROTECT_N(WRITE_PROTECT_N),
    .SUPPLY_LOW(SUPPLY_LOW));
  sse_host_model u_sse_host_model (
    .ser_clk(SER_CLK), .chip_select_n(CHIP_SELECT_N), .ser_in(SER_IN),
    .pause_transfer_n(PAUSE_TRANSFER_N), .ser_out(SER_OUT), .ser_out_oe(SER_OUT_OE));

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  function automatic logic [31:0] rng();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] exp_mem(input logic [14:0] a);
    return ref_mem.exists(int'(a)) ? ref_mem[int'(a)] : ARRAY_INIT;
  endfunction
  function automatic logic [7:0] exp_st();
    return {nv[2], 3'h0, nv[1:0], wel, 1'b0};
  endfunction
  function automatic logic prot(input logic [14:0] a);
    return (nv[1:0] == 2'h3) || (nv[1:0] == 2'h2 && a >= 15'h4000)
      || (nv[1:0] == 2'h1 && a >= 15'h6000);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic go();
    logic [31:0] m;
    m = rng();
    u_sse_host_model.begin_frame(m[0]);
  endtask
  task automatic cmd(input logic [7:0] op);
    go();
    u_sse_host_model.shift(op, 8, rx);
    u_sse_host_model.end_frame();
    if (op == OP_LATCH_SET) wel = 1'b1;
    if (op == OP_LATCH_CLEAR) wel = 1'b0;
  endtask
  task automatic stat_rd(output logic [7:0] s);
    go();
    u_sse_host_model.shift(OP_STAT_READ, 8, rx);
    u_sse_host_model.shift(8'h00, 8, s);
    u_sse_host_model.end_frame();
  endtask
  task automatic settle();
    int i;
    for (i = 0; i < 40; i++) begin
      stat_rd(st);
      if (st[0] === 1'b0) break;
    end
    check(st, exp_st());
  endtask
  task automatic send_addr(input logic [7:0] op, input logic [14:0] a);
    go();
    u_sse_host_model.shift(op, 8, rx);
    u_sse_host_model.shift({1'b0, a[14:8]}, 8, rx);
    u_sse_host_model.shift(a[7:0], 8, rx);
  endtask
  // Last byte may be cut short to cancel the write
  task automatic wr(input logic [14:0] a, input int nb, input int cut);
    logic [31:0] m;
    logic        ok;
    int          i;
    ok = wel && !prot(a) && !SUPPLY_LOW && cut == 8;
    send_addr(OP_WRITE, a);
    for (i = 0; i < nb; i++) begin
      m = rng();
      u_sse_host_model.shift(m[7:0], (i == nb - 1) ? cut : 8, rx);
      if (ok) ref_mem[int'({a[14:6], 6'(a[5:0] + i)})] = m[7:0];
    end
    u_sse_host_model.end_frame();
    if (ok) wel = 1'b0;
  endtask
  task automatic cmd_status_write(input logic [7:0] d);
    logic ok;
    ok = wel && !(nv[2] && !WRITE_PROTECT_N);
    go();
    u_sse_host_model.shift(OP_STAT_WRITE, 8, rx);
    u_sse_host_model.shift(d, 8, rx);
    u_sse_host_model.end_frame();
    if (ok) begin
      nv = {d[7], d[3:2]};
      wel = 1'b0;
    end else begin
      cmd(OP_LATCH_CLEAR);
    end
    settle();
  endtask
  task automatic rd_chk(input logic [14:0] a, input int nb);
    int i;
    send_addr(OP_READ, a);
    for (i = 0; i < nb; i++) begin
      u_sse_host_model.shift(8'h00, 8, rx);
      check(rx, exp_mem(a + 15'(i)));
    end
    u_sse_host_model.end_frame();
  endtask
  task automatic power_cycle();
    @(negedge CLK) RST_B = 1'b0;
    repeat (3) @(negedge CLK);
    RST_B = 1'b1;
    repeat (4) @(negedge CLK);
    wel = 1'b0;
  endtask

  initial begin
    #900_000;
    miscompares++;
    stop_test();
  end

  initial begin
    seed = 32'h3AB8;
    miscompares = 0;
    checked = 0;
    nv = NV_INIT;
    wel = 1'b0;
    RST_B = 1'b0;
    WRITE_PROTECT_N = 1'b1;
    SUPPLY_LOW = 1'b0;
    power_cycle();
    stat_rd(st);
    check(st, 32'h00);
    rd_chk(15'h2A00, 4);
    wr(15'h2A01, 1, 8);
    settle();
    rd_chk(15'h2A01, 1);
    cmd(OP_LATCH_SET);
    cmd(OP_LATCH_CLEAR);
    wr(15'h2A02, 1, 8);
    settle();
    rd_chk(15'h2A02, 1);
    cmd(OP_LATCH_SET);
    stat_rd(st);
    check(st, exp_st());
    wr(15'h1234, 70, 8);
    stat_rd(st);
    check(st[0], 1'b1);
    settle();
    rd_chk(15'h1200, 64);
    cmd(OP_LATCH_SET);
    wr(15'h0300, 2, 7);
    cmd(OP_LATCH_CLEAR);
    settle();
    rd_chk(15'h0300, 2);
    cmd(OP_LATCH_SET);
    cmd_status_write(8'hFF);
    check(st, 32'h8C);
    cmd(OP_LATCH_SET);
    wr(15'h1234, 1, 8);
    settle();
    rd_chk(15'h1234, 1);
    @(negedge CLK) WRITE_PROTECT_N = 1'b0;
    cmd_status_write(8'h00);
    @(negedge CLK) WRITE_PROTECT_N = 1'b1;
    cmd(OP_LATCH_SET);
    cmd_status_write(8'h04);
    cmd(OP_LATCH_SET);
    wr(15'h5FFF, 1, 8);
    settle();
    cmd(OP_LATCH_SET);
    wr(15'h6000, 1, 8);
    cmd(OP_LATCH_CLEAR);
    settle();
    rd_chk(15'h5FFF, 2);
    u_sse_host_model.hold_bit = 11;
    stat_rd(st);
    check(st, exp_st());
    check(u_sse_host_model.hold_oe, 1'b0);
    @(negedge CLK) SUPPLY_LOW = 1'b1;
    cmd(OP_LATCH_SET);
    wr(15'h0040, 3, 8);
    cmd(OP_LATCH_CLEAR);
    @(negedge CLK) SUPPLY_LOW = 1'b0;
    settle();
    rd_chk(15'h0040, 3);
    cmd(OP_LATCH_SET);
    power_cycle();
    stat_rd(st);
    check(st, 32'h04);
    cmd(OP_LATCH_SET);
    cmd_status_write(8'h00);
    for (n = 0; n < 6; n++) begin
      r = rng();
      cmd(OP_LATCH_SET);
      wr(r[14:0], int'(r[18:16]) + 1, 8);
      settle();
      rd_chk(r[14:0], int'(r[18:16]) + 1);
    end
    rd_chk(15'h7FFE, 4);
    stop_test();
  end
endmodule
